// >>> ddr_mr1_pkg.sv
// Constants and types shared by the extended mode register block
package ddr_mr1_pkg;
  localparam int          MR_W          = 18;
  localparam int          LAT_W         = 5;
  localparam logic [1:0]  SEL_MR0       = 2'h0;
  localparam logic [1:0]  SEL_MR1       = 2'h1;
  localparam logic [1:0]  SEL_MR2       = 2'h2;
  localparam logic [17:0] MR0_RST       = 18'h00000;
  localparam logic [17:0] MR1_RST       = 18'h00000;
  localparam logic [17:0] MR2_RST       = 18'h00000;
  localparam int          DLL_DIS_BIT   = 0;
  localparam int          DRV_LO_BIT    = 1;
  localparam int          DRV_HI_BIT    = 5;
  localparam int          NTERM_B0_BIT  = 2;
  localparam int          NTERM_B1_BIT  = 6;
  localparam int          NTERM_B2_BIT  = 9;
  localparam int          AL_LO_BIT     = 3;
  localparam int          WLEV_BIT      = 7;
  localparam int          TSTROBE_BIT   = 11;
  localparam int          QOFF_BIT      = 12;
  localparam int          DLL_RST_BIT   = 8;
  localparam int          CL_LO_BIT     = 4;
  localparam int          CWL_LO_BIT    = 3;
  localparam int          DYN_LO_BIT    = 9;
  localparam logic [4:0]  CL_BASE       = 5'h04;
  localparam logic [4:0]  CWL_BASE      = 5'h05;
  localparam logic [1:0]  DRV_RZQ7      = 2'h0;
  localparam logic [3:0]  MOD_CK        = 4'hC;
  localparam logic [2:0]  BURST_CK      = 3'h4;
  typedef enum logic [2:0] {CMD_NOP, CMD_MRS, CMD_RD, CMD_WR, CMD_REF, CMD_ZQ} cmd_e;
endpackage

// >>> lat_if.sv
// Carrier between command decode and the additive latency pipe
`timescale 1ns/10ps
interface lat_if;
  logic       step;
  logic       rd_in;
  logic       wr_in;
  logic [4:0] al;
  logic [4:0] cl;
  logic [4:0] cwl;
  logic       rd_rel;
  logic       wr_rel;
  logic       rd_dat;
  logic       wr_dat;
  modport ctl  (output step, rd_in, wr_in, al, cl, cwl, input rd_rel, wr_rel, rd_dat, wr_dat);
  modport pipe (input step, rd_in, wr_in, al, cl, cwl, output rd_rel, wr_rel, rd_dat, wr_dat);
endinterface

// >>> lat_pipe.sv
// Command delay line: internal release after AL, data start after RL or WL
`timescale 1ns/10ps
module lat_pipe (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // Latency taps
  lat_if.pipe       lp
);
  logic [31:0] rd_sh_q;
  logic [31:0] wr_sh_q;

  // Tap k of the line is the command seen k command-clock edges ago
  function automatic logic tap(input logic [31:0] sh, input logic now, input logic [4:0] k);
    tap = (k == 5'h00) ? now : sh[k - 5'h01];
  endfunction

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_sh_q <= 32'h00000000;
      wr_sh_q <= 32'h00000000;
    end else if (lp.step) begin
      rd_sh_q <= {rd_sh_q[30:0], lp.rd_in};
      wr_sh_q <= {wr_sh_q[30:0], lp.wr_in};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lp.rd_rel <= 1'b0;
      lp.wr_rel <= 1'b0;
      lp.rd_dat <= 1'b0;
      lp.wr_dat <= 1'b0;
    end else begin
      lp.rd_rel <= lp.step && tap(rd_sh_q, lp.rd_in, lp.al);
      lp.wr_rel <= lp.step && tap(wr_sh_q, lp.wr_in, lp.al);
      lp.rd_dat <= lp.step && tap(rd_sh_q, lp.rd_in, 5'(lp.al + lp.cl));
      lp.wr_dat <= lp.step && tap(wr_sh_q, lp.wr_in, 5'(lp.al + lp.cwl));
    end
  end
endmodule

// >>> ddr_extended_mode_config.sv
// Extended mode register decode and its effect on DLL, drivers and termination
`timescale 1ns/10ps
module ddr_extended_mode_config (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Memory command pins
  input  wire logic        ck,
  input  wire logic        cke,
  input  wire logic        reset_n,
  input  wire logic        cs_n,
  input  wire logic        ras_n,
  input  wire logic        cas_n,
  input  wire logic        we_n,
  input  wire logic [2:0]  ba,
  input  wire logic [15:0] addr,
  input  wire logic        odt,
  // DLL and drivers
  output logic             dll_on,
  output logic             edge_aligned,
  output logic [1:0]       drive_sel,
  output logic             drive_rzq7,
  output logic             data_oe_n,
  output logic             zq_update,
  // Termination, mask and write leveling
  output logic [2:0]       nominal_termination,
  output logic             term_on,
  output logic             write_termination_on,
  output logic             termination_strobe_on,
  output logic             dm_enable,
  output logic             write_leveling,
  // Latencies and internal command release
  output logic [4:0]       add_lat,
  output logic [4:0]       read_lat,
  output logic [4:0]       write_lat,
  output logic             read_release,
  output logic             write_release
);
  typedef enum logic {MS_IDLE, MS_WAIT} ms_e;

  logic [26:0]  s1_q;
  logic [26:0]  s2_q;
  logic         ck_prev_q;
  logic         step;
  ddr_mr1_pkg::cmd_e cmd;
  logic [17:0]  mr0_q;
  logic [17:0]  mr1_q;
  logic [17:0]  mr2_q;
  logic [17:0]  pend_q;
  logic [1:0]   pend_sel_q;
  ms_e          ms_q;
  logic [3:0]   mod_cnt_q;
  logic         apply;
  logic         sr_q;
  logic         sr_keep_q;
  logic         dll_on_q;
  logic [2:0]   rd_cnt_q;
  logic [2:0]   wr_cnt_q;
  logic [4:0]   cl;
  logic         dll_en;
  logic         nterm_en;
  logic         dyn_en;
  lat_if        lp ();

  // Pins cross from the memory clock domain through two stages
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s1_q      <= 27'h0000000;
      s2_q      <= 27'h0000000;
      ck_prev_q <= 1'b0;
    end else begin
      s1_q      <= {ck, cke, reset_n, cs_n, ras_n, cas_n, we_n, ba, addr, odt};
      s2_q      <= s1_q;
      ck_prev_q <= s2_q[26];
    end
  end

  function automatic ddr_mr1_pkg::cmd_e decode(input logic [3:0] c);
    unique case (c)
      4'h0:    decode = ddr_mr1_pkg::CMD_MRS;
      4'h1:    decode = ddr_mr1_pkg::CMD_REF;
      4'h5:    decode = ddr_mr1_pkg::CMD_RD;
      4'h4:    decode = ddr_mr1_pkg::CMD_WR;
      4'h6:    decode = ddr_mr1_pkg::CMD_ZQ;
      default: decode = ddr_mr1_pkg::CMD_NOP;
    endcase
  endfunction

  function automatic logic [4:0] al_of(input logic [1:0] f, input logic [4:0] c);
    unique case (f)
      2'h1:    al_of = 5'(c - 5'h01);
      2'h2:    al_of = 5'(c - 5'h02);
      default: al_of = 5'h00;
    endcase
  endfunction

  assign step       = s2_q[26] && !ck_prev_q;
  assign cmd        = decode(s2_q[23:20]);
  assign cl         = 5'(mr0_q[ddr_mr1_pkg::CL_LO_BIT +: 3] + ddr_mr1_pkg::CL_BASE);
  assign dll_en     = !mr1_q[ddr_mr1_pkg::DLL_DIS_BIT];
  assign nterm_en   = {mr1_q[ddr_mr1_pkg::NTERM_B2_BIT], mr1_q[ddr_mr1_pkg::NTERM_B1_BIT],
                       mr1_q[ddr_mr1_pkg::NTERM_B0_BIT]} != 3'h0;
  assign dyn_en     = mr2_q[ddr_mr1_pkg::DYN_LO_BIT +: 2] != 2'h0;
  assign apply      = step && (ms_q == MS_WAIT) && (mod_cnt_q == 4'h1);

  // Mode write is held pending for the mode-set delay, then applied
  always_ff @(posedge ref_clk) begin
    if (rst || !s2_q[24]) begin
      ms_q       <= MS_IDLE;
      mod_cnt_q  <= 4'h0;
      pend_q     <= ddr_mr1_pkg::MR1_RST;
      pend_sel_q <= ddr_mr1_pkg::SEL_MR0;
    end else if (step) begin
      unique case (ms_q)
        MS_IDLE: if (cmd == ddr_mr1_pkg::CMD_MRS) begin
          ms_q       <= MS_WAIT;
          mod_cnt_q  <= ddr_mr1_pkg::MOD_CK;
          pend_q     <= {s2_q[18:17], s2_q[16:1]};
          pend_sel_q <= s2_q[18:17];
        end
        MS_WAIT: begin
          mod_cnt_q <= 4'(mod_cnt_q - 4'h1);
          if (mod_cnt_q == 4'h1) begin
            ms_q <= MS_IDLE;
          end
        end
      endcase
    end
  end

  // Contents survive until rewritten or the device reset pin goes low
  always_ff @(posedge ref_clk) begin
    if (rst || !s2_q[24]) begin
      mr0_q <= ddr_mr1_pkg::MR0_RST;
      mr1_q <= ddr_mr1_pkg::MR1_RST;
      mr2_q <= ddr_mr1_pkg::MR2_RST;
    end else if (apply) begin
      if (pend_sel_q == ddr_mr1_pkg::SEL_MR0) begin
        mr0_q <= pend_q;
      end
      if (pend_sel_q == ddr_mr1_pkg::SEL_MR1) begin
        mr1_q <= pend_q;
      end
      if (pend_sel_q == ddr_mr1_pkg::SEL_MR2) begin
        mr2_q <= pend_q;
      end
    end
  end

  // Self refresh: refresh with clock enable low enters, clock enable high leaves
  always_ff @(posedge ref_clk) begin
    if (rst || !s2_q[24]) begin
      sr_q <= 1'b0;
    end else if (step) begin
      if (!sr_q && cmd == ddr_mr1_pkg::CMD_REF && !s2_q[25]) begin
        sr_q <= 1'b1;
      end else if (sr_q && s2_q[25]) begin
        sr_q <= 1'b0;
      end
    end
  end

  // DLL runs only after enable plus DLL reset; self refresh parks it
  always_ff @(posedge ref_clk) begin
    if (rst || !s2_q[24]) begin
      dll_on_q  <= 1'b0;
      sr_keep_q <= 1'b0;
    end else if (step && !sr_q && cmd == ddr_mr1_pkg::CMD_REF && !s2_q[25]) begin
      dll_on_q  <= 1'b0;
      sr_keep_q <= dll_on_q;
    end else if (step && sr_q && s2_q[25]) begin
      dll_on_q <= sr_keep_q && dll_en;
    end else if (apply && pend_sel_q == ddr_mr1_pkg::SEL_MR1 &&
                 pend_q[ddr_mr1_pkg::DLL_DIS_BIT]) begin
      dll_on_q <= 1'b0;
    end else if (apply && pend_sel_q == ddr_mr1_pkg::SEL_MR0 &&
                 pend_q[ddr_mr1_pkg::DLL_RST_BIT] && dll_en) begin
      dll_on_q <= 1'b1;
    end
  end

  assign lp.step  = step;
  assign lp.rd_in = step && !sr_q && cmd == ddr_mr1_pkg::CMD_RD;
  assign lp.wr_in = step && !sr_q && cmd == ddr_mr1_pkg::CMD_WR;
  assign lp.al    = add_lat;
  assign lp.cl    = cl;
  assign lp.cwl   = 5'(mr2_q[ddr_mr1_pkg::CWL_LO_BIT +: 3] + ddr_mr1_pkg::CWL_BASE);

  lat_pipe u_pipe (
    .ref_clk (ref_clk),
    .rst     (rst),
    .lp      (lp)
  );

  // Burst windows last four command clocks (eight beats)
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_cnt_q <= 3'h0;
      wr_cnt_q <= 3'h0;
    end else begin
      if (lp.rd_dat) begin
        rd_cnt_q <= ddr_mr1_pkg::BURST_CK;
      end else if (step && rd_cnt_q != 3'h0) begin
        rd_cnt_q <= 3'(rd_cnt_q - 3'h1);
      end
      if (lp.wr_dat) begin
        wr_cnt_q <= ddr_mr1_pkg::BURST_CK;
      end else if (step && wr_cnt_q != 3'h0) begin
        wr_cnt_q <= 3'(wr_cnt_q - 3'h1);
      end
    end
  end

  // Field outputs; calibration updates never gate any of them
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dll_on        <= 1'b0;
      edge_aligned  <= 1'b0;
      drive_sel     <= ddr_mr1_pkg::DRV_RZQ7;
      drive_rzq7    <= 1'b1;
      zq_update     <= 1'b0;
      write_leveling <= 1'b0;
      add_lat       <= 5'h00;
      read_lat      <= 5'h00;
      write_lat     <= 5'h00;
      read_release  <= 1'b0;
      write_release <= 1'b0;
    end else begin
      dll_on        <= dll_on_q;
      edge_aligned  <= dll_on_q;
      drive_sel     <= {mr1_q[ddr_mr1_pkg::DRV_HI_BIT], mr1_q[ddr_mr1_pkg::DRV_LO_BIT]};
      drive_rzq7    <= {mr1_q[ddr_mr1_pkg::DRV_HI_BIT], mr1_q[ddr_mr1_pkg::DRV_LO_BIT]} ==
                       ddr_mr1_pkg::DRV_RZQ7;
      zq_update     <= step && cmd == ddr_mr1_pkg::CMD_ZQ;
      write_leveling <= mr1_q[ddr_mr1_pkg::WLEV_BIT];
      add_lat       <= al_of(mr1_q[ddr_mr1_pkg::AL_LO_BIT +: 2], cl);
      read_lat      <= 5'(add_lat + cl);
      write_lat     <= 5'(add_lat + lp.cwl);
      read_release  <= lp.rd_rel;
      write_release <= lp.wr_rel;
    end
  end

  // term_on and the strobe termination are never on while a read burst runs; write_termination_on is not gated by it
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      data_oe_n             <= 1'b1;
      nominal_termination   <= 3'h0;
      term_on               <= 1'b0;
      write_termination_on  <= 1'b0;
      termination_strobe_on <= 1'b0;
      dm_enable             <= 1'b1;
    end else begin
      data_oe_n            <= !(rd_cnt_q != 3'h0 && !mr1_q[ddr_mr1_pkg::QOFF_BIT]);
      nominal_termination  <= {mr1_q[ddr_mr1_pkg::NTERM_B2_BIT], mr1_q[ddr_mr1_pkg::NTERM_B1_BIT],
                               mr1_q[ddr_mr1_pkg::NTERM_B0_BIT]};
      write_termination_on <= wr_cnt_q != 3'h0 && dyn_en && !mr1_q[ddr_mr1_pkg::WLEV_BIT];
      term_on              <= !sr_q && rd_cnt_q == 3'h0 &&
                              ((s2_q[0] && nterm_en) || (wr_cnt_q != 3'h0 && dyn_en));
      termination_strobe_on <= mr1_q[ddr_mr1_pkg::TSTROBE_BIT] && !sr_q && rd_cnt_q == 3'h0 &&
                              ((s2_q[0] && nterm_en) || (wr_cnt_q != 3'h0 && dyn_en));
      dm_enable            <= !mr1_q[ddr_mr1_pkg::TSTROBE_BIT];
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence mrs_taken;
    step && ms_q == MS_IDLE && cmd == ddr_mr1_pkg::CMD_MRS;
  endsequence
  sequence sr_exit_parked;
    $fell(sr_q) && !$past(sr_keep_q);
  endsequence

  AST_MODE_HOLD: assert property (mrs_taken |=> $stable(mr1_q)[*8])
    else $error("mode register changed before mode-set delay");
  AST_SR_DLL_OFF: assert property (sr_q |-> !dll_on_q)
    else $error("DLL running in self refresh");
  AST_SR_EXIT_OFF: assert property (sr_exit_parked |-> !dll_on_q)
    else $error("DLL came back after self refresh though it was off");
  AST_DLL_ROSE: assert property ($rose(dll_on_q) |-> $past(dll_en) || $past(sr_q))
    else $error("DLL on while disabled");
  AST_QOFF: assert property (mr1_q[ddr_mr1_pkg::QOFF_BIT] && $past(mr1_q[ddr_mr1_pkg::QOFF_BIT])
                             |-> data_oe_n)
    else $error("outputs driven while disabled");
  AST_DM: assert property (##1 dm_enable == !$past(mr1_q[ddr_mr1_pkg::TSTROBE_BIT]))
    else $error("data mask state wrong");
  AST_TERMINATION_STROBE_TERM: assert property (termination_strobe_on |-> term_on && !dm_enable)
    else $error("termination strobe termination without enable");
  AST_TERM_IDLE: assert property ($past(!s2_q[0] && wr_cnt_q == 3'h0) |-> !term_on)
    else $error("termination on without control pin");
  AST_AL0: assert property (lp.rd_in && add_lat == 5'h00 |=> lp.rd_rel)
    else $error("read not released with zero additive latency");
  // Read latency trails its terms by one cycle, so compare against their past values
  AST_RL: assert property (!$past(rst) |-> read_lat == 5'($past(add_lat) + $past(cl)))
    else $error("read latency not AL plus CL");
endmodule

// >>> ddr_ctl_model.sv
// Behavioural memory controller: command clock, command pins and termination control
`timescale 1ns/10ps
module ddr_ctl_model (
  // Clock
  input  wire logic  ref_clk,
  // Memory command pins
  output logic        ck,
  output logic        cke,
  output logic        reset_n,
  output logic        cs_n,
  output logic        ras_n,
  output logic        cas_n,
  output logic        we_n,
  output logic [2:0]  ba,
  output logic [15:0] addr,
  output logic        odt
);
  logic [1:0] div_q = 2'h0;
  int         rises = 0;
  int         last_cmd = 0;

  initial begin
    ck = 1'b0;
    {cke, reset_n, cs_n, ras_n, cas_n, we_n, odt} = 7'h7E;
    {ba, addr} = 19'h00000;
  end

  // The command clock runs free, as a memory clock does
  always @(posedge ref_clk) begin
    div_q <= div_q + 2'h1;
    if (div_q == 2'h3) begin
      ck <= ~ck;
      if (!ck) begin
        rises <= rises + 1;
      end
    end
  end

  task automatic wait_fall;
    @(posedge ref_clk);
    while (!(div_q == 2'h3 && ck)) begin
      @(posedge ref_clk);
    end
  endtask

  // Pins change as ck falls and hold a full period; once deselected the bus shows the inverse
  // Only one-byte-wide use is modelled, so the termination strobe may be enabled
  task automatic issue(input logic [3:0] code, input logic [17:0] word, input logic cke_v);
    wait_fall();
    {cs_n, ras_n, cas_n, we_n} <= code;
    {ba, addr} <= {1'b0, word};
    cke <= cke_v;
    last_cmd <= rises + 1;
    wait_fall();
    {cs_n, ras_n, cas_n, we_n} <= 4'hF;
    {ba, addr} <= ~{1'b0, word};
  endtask

  task automatic set_odt(input logic v);
    @(posedge ref_clk);
    odt <= v;
  endtask

  task automatic pulse_reset;
    @(posedge ref_clk);
    reset_n <= 1'b0;
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
  endtask
endmodule

// >>> tb_ddr_extended_mode_config.sv
// Self-checking bench for the extended mode register block
`timescale 1ns/10ps
module tb_ddr_extended_mode_config;
  logic        ref_clk, rst, ck, cke, reset_n, cs_n, ras_n, cas_n, we_n, odt;
  logic [2:0]  ba;
  logic [15:0] addr;
  logic        dll_on, edge_aligned, drive_rzq7, data_oe_n, zq_update, term_on, oe_prev;
  logic        write_termination_on, termination_strobe_on, dm_enable, write_leveling;
  logic        read_release, write_release;
  logic [1:0]  drive_sel, dyn;
  logic [2:0]  nominal_termination;
  logic [4:0]  add_lat, read_lat, write_lat, cl, cwl;
  logic [17:0] m1, prev;
  logic [31:0] r;
  int          errors = 0, n_compared = 0, seed = 32'hA124A61C;
  int          n_rel = 0, n_wr = 0, n_oe = 0, n_wt = 0, n_zq = 0, rel_rise, wr_rise, oe_rise;

  ddr_ctl_model ddr_ctl_model_inst (
    .ref_clk(ref_clk), .ck(ck), .cke(cke), .reset_n(reset_n), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .odt(odt)
  );
  ddr_extended_mode_config ddr_extended_mode_config_inst (
    .ref_clk(ref_clk), .rst(rst), .ck(ck), .cke(cke), .reset_n(reset_n), .cs_n(cs_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .odt(odt),
    .dll_on(dll_on), .edge_aligned(edge_aligned), .drive_sel(drive_sel),
    .drive_rzq7(drive_rzq7), .data_oe_n(data_oe_n), .zq_update(zq_update),
    .nominal_termination(nominal_termination), .term_on(term_on),
    .write_termination_on(write_termination_on),
    .termination_strobe_on(termination_strobe_on), .dm_enable(dm_enable),
    .write_leveling(write_leveling), .add_lat(add_lat), .read_lat(read_lat),
    .write_lat(write_lat), .read_release(read_release), .write_release(write_release)
  );

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // Counters catch answers that arrive before the command task has returned
  always @(posedge ref_clk) begin
    oe_prev <= data_oe_n;
    if (read_release === 1'b1) begin
      n_rel <= n_rel + 1;
      rel_rise <= ddr_ctl_model_inst.rises;
    end
    if (write_release === 1'b1) begin
      n_wr <= n_wr + 1;
      wr_rise <= ddr_ctl_model_inst.rises;
    end
    if (oe_prev === 1'b1 && data_oe_n === 1'b0) begin
      n_oe <= n_oe + 1;
      oe_rise <= ddr_ctl_model_inst.rises;
    end
    if (write_termination_on === 1'b1) n_wt <= n_wt + 1;
    if (zq_update === 1'b1) n_zq <= n_zq + 1;
  end

  task automatic cmp(input logic [4:0] got, input logic [4:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  task automatic cmp_n(input int got, input int exp, input string what);
    n_compared++;
    if (got != exp) begin
      errors++;
      $display("ERROR at %0t: %s got %0d expected %0d", $time, what, got, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("Compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  function automatic logic [4:0] exp_al(input logic [17:0] m);
    case (m[4:3])
      2'h1: return cl - 5'h01;
      2'h2: return cl - 5'h02;
      default: return 5'h00;
    endcase
  endfunction

  function automatic logic [17:0] mr0_word(input logic dll_reset);
    return {ddr_mr1_pkg::SEL_MR0, 7'h00, dll_reset, 1'b0, 3'(cl - ddr_mr1_pkg::CL_BASE), 4'h0};
  endfunction

  function automatic logic [17:0] mr2_word();
    return {ddr_mr1_pkg::SEL_MR2, 5'h00, dyn, 3'h0, 3'(cwl - ddr_mr1_pkg::CWL_BASE), 3'h0};
  endfunction

  task automatic issue(input logic [3:0] c, input logic [17:0] w, input logic k);
    ddr_ctl_model_inst.issue(c, w, k);
  endtask

  // Mode words go out only with all banks idle and no burst running
  task automatic mode_wr(input logic [17:0] w);
    issue(4'h0, w, 1'b1);
    repeat (104) @(posedge ref_clk);
  endtask

  task automatic check_fields(input logic [17:0] m);
    cmp(5'(drive_sel), 5'({m[5], m[1]}), "drive_sel");
    cmp(5'(drive_rzq7), 5'({m[5], m[1]} == ddr_mr1_pkg::DRV_RZQ7), "rzq7");
    cmp(5'(nominal_termination), 5'({m[9], m[6], m[2]}), "nominal");
    cmp(5'(dm_enable), 5'(!m[11]), "dm_enable");
    cmp(5'(write_leveling), 5'(m[7]), "leveling");
    cmp(add_lat, exp_al(m), "add_lat");
    cmp(read_lat, exp_al(m) + cl, "read_lat");
    cmp(write_lat, exp_al(m) + cwl, "write_lat");
  endtask

  task automatic self_refresh(input logic dll_exp);
    issue(4'h1, 18'h00000, 1'b0);
    repeat (16) @(posedge ref_clk);
    cmp(5'(dll_on), 5'h00, "dll in self refresh");
    issue(4'hF, 18'h00000, 1'b1);
    repeat (16) @(posedge ref_clk);
    cmp(5'(dll_on), 5'(dll_exp), "dll after self refresh");
  endtask

  task automatic traffic(input logic [17:0] m);
    int         c_oe, c_rel, c_wr, c_wt;
    logic [4:0] al;
    al = exp_al(m);
    ddr_ctl_model_inst.set_odt(1'b1);
    repeat (8) @(posedge ref_clk);
    cmp(5'(term_on), 5'(|{m[9], m[6], m[2]}), "term_on");
    cmp(5'(termination_strobe_on), 5'(m[11] & |{m[9], m[6], m[2]}), "strobe term");
    ddr_ctl_model_inst.set_odt(1'b0);
    repeat (8) @(posedge ref_clk);
    cmp(5'(term_on), 5'h00, "term_on off");
    c_oe = n_oe;
    c_rel = n_rel;
    // Rows count as opened long before, so activate spacing plus AL stays legal
    issue(4'h5, {2'h0, r[15:0]}, 1'b1);
    repeat (8 * (al + cl + 6)) @(posedge ref_clk);
    cmp_n(n_rel - c_rel, 1, "read releases");
    cmp_n(rel_rise - ddr_ctl_model_inst.last_cmd, al, "read hold");
    cmp_n(n_oe - c_oe, m[12] ? 0 : 1, "read bursts driven");
    if (!m[12]) cmp_n(oe_rise - ddr_ctl_model_inst.last_cmd, al + cl, "read lat");
    c_wr = n_wr;
    c_wt = n_wt;
    issue(4'h4, {2'h0, ~r[15:0]}, 1'b1);
    repeat (8 * (al + cwl + 6)) @(posedge ref_clk);
    cmp_n(n_wr - c_wr, 1, "write releases");
    cmp_n(wr_rise - ddr_ctl_model_inst.last_cmd, al, "write hold");
    cmp_n(int'(n_wt > c_wt), int'(dyn != 2'h0), "write termination");
  endtask

  initial begin
    repeat (100000) @(posedge ref_clk);
    errors++;
    report_and_stop();
  end

  initial begin
    int c;
    rst = 1'b1;
    r = 32'h00000000;
    dyn = 2'h0;
    cl = 5'h06;
    cwl = 5'h06;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (8) @(posedge ref_clk);
    cmp(5'(dll_on), 5'h00, "dll at reset");
    cmp(5'(data_oe_n), 5'h01, "oe at reset");
    mode_wr(mr2_word());
    mode_wr({ddr_mr1_pkg::SEL_MR1, 16'h0000});
    mode_wr(mr0_word(1'b1));
    issue(4'h6, 18'h00000, 1'b1);
    repeat (16) @(posedge ref_clk);
    prev = {ddr_mr1_pkg::SEL_MR1, 16'h0000};
    for (int i = 0; i < 6; i++) begin
      r = $random(seed);
      cl = ddr_mr1_pkg::CL_BASE + {2'h0, r[2:0]};
      cwl = ddr_mr1_pkg::CWL_BASE + {2'h0, r[5:3]};
      dyn = r[6] ? 2'h0 : {r[7], ~r[7]};
      // Reserved bits and reserved drive and termination codes stay off the bus
      // Output disable rounds stand for read-current characterization runs
      m1 = {ddr_mr1_pkg::SEL_MR1, r[31:16] & 16'h1A5E};
      if (m1[9] && m1[6]) m1[9] = 1'b0;
      if (i == 0) m1[7:3] = {1'b1, m1[6:5], 2'h3};
      if (i == 1) m1[4:3] = 2'h2;
      if (i == 1) cl = ddr_mr1_pkg::CL_BASE;
      mode_wr(mr0_word(1'b0));
      mode_wr(mr2_word());
      issue(4'h0, m1, 1'b1);
      repeat (80) @(posedge ref_clk);
      check_fields(prev);
      repeat (24) @(posedge ref_clk);
      check_fields(m1);
      cmp(5'(dll_on), 5'h01, "dll kept");
      cmp(5'(edge_aligned), 5'h01, "aligned");
      if (!m1[7]) traffic(m1);
      prev = m1;
      $display("mode word test %0d done", i);
    end
    self_refresh(1'b1);
    cl = 5'h06;
    cwl = 5'h06;
    mode_wr(mr0_word(1'b0));
    mode_wr(mr2_word());
    mode_wr({ddr_mr1_pkg::SEL_MR1, 16'h0001});
    cmp(5'(dll_on), 5'h00, "dll disabled");
    cmp(5'(edge_aligned), 5'h00, "not aligned");
    self_refresh(1'b0);
    mode_wr({ddr_mr1_pkg::SEL_MR1, 16'h0206});
    cmp(5'(dll_on), 5'h00, "dll waits for reset");
    mode_wr(mr0_word(1'b1));
    cmp(5'(dll_on), 5'h01, "dll after reset");
    $display("dll and self refresh test done");
    c = n_zq;
    issue(4'h6, 18'h00000, 1'b1);
    repeat (16) @(posedge ref_clk);
    cmp_n(n_zq - c, 1, "calibration pulses");
    check_fields({ddr_mr1_pkg::SEL_MR1, 16'h0206});
    ddr_ctl_model_inst.pulse_reset();
    repeat (16) @(posedge ref_clk);
    cl = ddr_mr1_pkg::CL_BASE;
    cwl = ddr_mr1_pkg::CWL_BASE;
    check_fields({ddr_mr1_pkg::SEL_MR1, 16'h0000});
    cmp(5'(dll_on), 5'h00, "dll after pin reset");
    $display("calibration and pin reset test done");
    report_and_stop();
  end
endmodule
